// file: pma_pmd_octet_interface_tb_top.sv
`timescale 1ns/1ns
module pma_pmd_octet_interface_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic steady_state = 1'b0;
  poi_pkg::poi_octet_t a_tx_octet = 8'h00;
  logic a_tx_valid = 1'b0;
  logic a_tx_ready;
  poi_pkg::poi_octet_t a_rx_octet;
  logic a_rx_valid;
  logic rx_sync_indication;
  poi_pkg::poi_octet_t m_tx_octet;
  logic m_tx_valid;
  poi_pkg::poi_octet_t m_rx_octet = 8'h00;
  logic m_rx_valid = 1'b0;
  logic m_rx_ready;
  int n_errors = 0;
  int num_checks = 0;
  poi_pkg::poi_octet_t tx_q[$];
  poi_pkg::poi_octet_t tx_wq[$];
  poi_pkg::poi_octet_t rx_q[$];
  poi_pkg::poi_octet_t rx_wq[$];
  logic tp = 1'b0;
  logic tps = 1'b0;
  int tn = -1;
  int rn = -1;
  logic [7:0] tsh;
  logic [7:0] rsh;

  poi_link_if link ();
  always #25 clock = ~clock;

  // scrambling left off: its seed state is not observable at the ports
  poi_pma poi_pma_inst (.clock(clock), .reset(reset), .link(link),
    .tx_octet(a_tx_octet), .tx_valid(a_tx_valid), .tx_ready(a_tx_ready),
    .rx_octet(a_rx_octet), .rx_valid(a_rx_valid), .scramble_en(1'b0),
    .rx_sync_indication(rx_sync_indication));
  poi_pmd poi_pmd_inst (.clock(clock), .reset(reset), .link(link),
    .tx_rate_div(8'h02), .rx_rate_div(8'h01),
    .steady_state(steady_state),
    .tx_octet(m_tx_octet), .tx_valid(m_tx_valid), .rx_octet(m_rx_octet),
    .rx_valid(m_rx_valid), .rx_ready(m_rx_ready));
  poi_link_checker poi_link_checker_inst (.clock(clock), .reset(reset),
    .link_clk(link.link_clk), .link_reset(link.link_reset),
    .tx_line(link.tx_line), .rx_line(link.rx_line),
    .tx_octet_sync(link.tx_octet_sync), .rx_octet_sync(link.rx_octet_sync),
    .tx_bit_sync(link.tx_bit_sync), .rx_bit_sync(link.rx_bit_sync),
    .pmd_steady(link.pmd_steady),
    .rx_sync_indication(rx_sync_indication));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_eq(input string what, input logic [7:0] seen,
                          input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // empty queue yields unknown, so a surplus octet never matches
  function automatic logic [7:0] pop_q(ref poi_pkg::poi_octet_t q[$]);
    if (q.size() == 0) return 8'hxx;
    return q.pop_front();
  endfunction

  task automatic tick(inout int n);
    @(negedge clock);
    n++;
    if (n > 20000) begin
      n_errors++;
      $display("timeout waiting for the link");
      tally_and_finish();
    end
  endtask

  task automatic send_tx(input poi_pkg::poi_octet_t d);
    int n;
    n = 0;
    a_tx_octet = d;
    a_tx_valid = 1'b1;
    while (a_tx_ready !== 1'b1) tick(n);
    tx_q.push_back(d);
    tx_wq.push_back(d);
    tick(n);
  endtask

  task automatic send_rx(input poi_pkg::poi_octet_t d);
    int n;
    n = 0;
    m_rx_octet = d;
    m_rx_valid = 1'b1;
    do tick(n); while (m_rx_ready !== 1'b1);
    rx_q.push_back(d);
    rx_wq.push_back(d);
  endtask

  // idle octets are zero; user data is kept nonzero to tell them apart
  always @(negedge clock) begin
    if (m_tx_valid === 1'b1 && m_tx_octet !== 8'h00)
      check_eq("pmd tx octet", m_tx_octet, pop_q(tx_q));
    if (a_rx_valid === 1'b1 && a_rx_octet !== 8'h00)
      check_eq("pma rx octet", a_rx_octet, pop_q(rx_q));
  end

  // tx line is launched at a strobe rise and taken at the next rise
  always @(posedge link.link_clk) begin
    if (link.link_reset === 1'b1) begin
      tn = -1;
      rn = -1;
    end else begin
      if (tp === 1'b1) begin
        if (tps === 1'b1) tn = 0;
        if (tn >= 0) begin
          tsh = {tsh[6:0], link.tx_line};
          tn++;
        end
        if (tn == 8) begin
          if (tsh !== 8'h00) check_eq("tx wire", tsh, pop_q(tx_wq));
          tn = 0;
        end
      end
      if (link.rx_bit_sync === 1'b1) begin
        if (link.rx_octet_sync === 1'b1) rn = 0;
        if (rn >= 0) begin
          rsh = {rsh[6:0], link.rx_line};
          rn++;
        end
        if (rn == 8) begin
          if (rsh !== 8'h00) check_eq("rx wire", rsh, pop_q(rx_wq));
          rn = 0;
        end
      end
    end
    tp = link.tx_bit_sync;
    tps = link.tx_octet_sync;
  end

  initial begin
    int n;
    void'($urandom(32'h7cda35e8));
    n = 0;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    check_eq("sync at reset", {7'h00, rx_sync_indication}, 8'h00);
    steady_state = 1'b1;
    while (rx_sync_indication !== 1'b1) tick(n);
    check_eq("sync up", {7'h00, rx_sync_indication}, 8'h01);
    // each stream drops valid once done, or its last octet goes again
    fork
      begin
        repeat (24) send_tx(8'($urandom_range(255, 1)));
        a_tx_valid = 1'b0;
      end
      begin
        repeat (24) send_rx(8'($urandom_range(255, 1)));
        m_rx_valid = 1'b0;
      end
    join
    n = 0;
    while (tx_q.size() + tx_wq.size() + rx_q.size() + rx_wq.size() != 0)
      tick(n);
    steady_state = 1'b0;
    while (rx_sync_indication !== 1'b0) tick(n);
    check_eq("sync down", {7'h00, rx_sync_indication}, 8'h00);
    tally_and_finish();
  end
endmodule

// file: poi_link_checker.sv
`timescale 1ns/1ns
module poi_link_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic tx_line,
  input wire logic rx_line,
  input wire logic tx_octet_sync,
  input wire logic rx_octet_sync,
  input wire logic tx_bit_sync,
  input wire logic rx_bit_sync,
  input wire logic pmd_steady,
  input wire logic rx_sync_indication
);
  logic [3:0] tx_cnt;
  logic [3:0] rx_cnt;
  logic [3:0] next_tx_cnt;
  logic [3:0] next_rx_cnt;

  // strobes since the last octet mark; 0 means no mark seen yet
  always_comb begin
    next_tx_cnt = tx_cnt;
    next_rx_cnt = rx_cnt;
    if (tx_octet_sync) begin
      next_tx_cnt = 4'h1;
    end else if (tx_bit_sync && tx_cnt != 4'h0 && tx_cnt != 4'hf) begin
      next_tx_cnt = tx_cnt + 4'h1;
    end
    if (rx_octet_sync) begin
      next_rx_cnt = 4'h1;
    end else if (rx_bit_sync && rx_cnt != 4'h0 && rx_cnt != 4'hf) begin
      next_rx_cnt = rx_cnt + 4'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      tx_cnt <= 4'h0;
      rx_cnt <= 4'h0;
    end else begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
    end
  end

  sequence steady_up;
    $rose(pmd_steady);
  endsequence
  sequence steady_down;
    $fell(pmd_steady);
  endsequence

  chk_tx_mark_strobe: assert property (
    @(posedge link_clk) disable iff (link_reset) tx_octet_sync |-> tx_bit_sync)
    else $error("tx octet mark without bit strobe");
  chk_rx_mark_strobe: assert property (
    @(posedge link_clk) disable iff (link_reset) rx_octet_sync |-> rx_bit_sync)
    else $error("rx octet mark without bit strobe");
  chk_tx_octet_len: assert property (
    @(posedge link_clk) disable iff (link_reset)
    tx_octet_sync && tx_cnt != 4'h0 |-> tx_cnt == 4'h8)
    else $error("tx octet not eight strobes long");
  chk_rx_octet_len: assert property (
    @(posedge link_clk) disable iff (link_reset)
    rx_octet_sync && rx_cnt != 4'h0 |-> rx_cnt == 4'h8)
    else $error("rx octet not eight strobes long");
  chk_sync_rise: assert property (
    @(posedge clock) disable iff (reset) steady_up |-> ##2 rx_sync_indication)
    else $error("sync indication late on steady rise");
  chk_sync_fall: assert property (
    @(posedge clock) disable iff (reset) steady_down |-> ##2 !rx_sync_indication)
    else $error("sync indication late on steady fall");
  chk_link_clk_div: assert property (
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> link_clk != $past(link_clk))
    else $error("link clock not divided by two");
  chk_far_on_fall: assert property (
    @(posedge clock) disable iff (reset)
    $changed(rx_line) || $changed(tx_octet_sync) || $changed(rx_bit_sync)
    |-> !link_clk)
    else $error("far side changed off the link clock fall");
  chk_tx_on_rise: assert property (
    @(posedge clock) disable iff (reset) $changed(tx_line) |-> link_clk)
    else $error("tx line changed off the link clock rise");
  chk_quiet_reset: assert property (
    @(posedge clock) disable iff (reset)
    link_reset |-> !tx_octet_sync && !rx_octet_sync)
    else $error("octet mark during link reset");
endmodule

// file: poi_link_if.sv
`timescale 1ns/1ns
interface poi_link_if;
  logic link_clk;
  logic link_reset;
  logic tx_line;
  logic rx_line;
  logic tx_octet_sync;
  logic rx_octet_sync;
  logic tx_bit_sync;
  logic rx_bit_sync;
  logic pmd_steady;

  // same signal set at both ends of the line, either office or remote
  modport pma (
    input link_clk,
    input link_reset,
    input rx_line,
    input tx_octet_sync,
    input rx_octet_sync,
    input tx_bit_sync,
    input rx_bit_sync,
    input pmd_steady,
    output tx_line
  );
  modport pmd (
    output link_clk,
    output link_reset,
    output rx_line,
    output tx_octet_sync,
    output rx_octet_sync,
    output tx_bit_sync,
    output rx_bit_sync,
    output pmd_steady,
    input tx_line
  );
endinterface

// file: poi_pkg.sv
package poi_pkg;
  localparam int OCTET_W = 8;
  typedef logic [OCTET_W-1:0] poi_octet_t;
  localparam poi_octet_t IDLE_OCTET = 8'h00;
  localparam int BIT_CNT_W = 3;
  typedef logic [BIT_CNT_W-1:0] poi_bit_idx_t;
  localparam poi_bit_idx_t BIT_FIRST = 3'h0;
  localparam poi_bit_idx_t BIT_LAST = 3'h7;
  // self-synchronising scrambler, taps are plain defaults
  localparam int SCR_LEN = 23;
  localparam int SCR_TAP_A = 18;
  localparam int SCR_TAP_B = 23;
  // system clocks per link clock period, at least 2
  localparam int LINK_DIV = 2;
  localparam int LINK_RST_CYCLES = 4;
  localparam int RATE_W = 8;
endpackage

// file: poi_pma.sv
`timescale 1ns/1ns
// Behaviour
// RULE1: two octet streams, transmit out, receive in
// RULE2: serial octets go most significant bit first
// RULE3: bit rate fixed by configured transmission profile
// RULE4: far side drives both octet timing signals
// RULE5: bit timing optional; work without it
// RULE6: highest-numbered octet bit goes out first
// RULE7: same bit is processed first, as LSB
// RULE8: interleaved path only, no fast path
// RULE9: identical data and timing flows both ends
// RULE10: one octet per octet timing event
// RULE11: receive-synchronised only in steady-state transmission
module poi_pma #(
  parameter bit HAS_BIT_TIMING = 1'b1
) (
  input wire logic clock,
  input wire logic reset,
  poi_link_if.pma link, // RULE9
  input wire poi_pkg::poi_octet_t tx_octet,
  input wire logic tx_valid,
  output logic tx_ready,
  output poi_pkg::poi_octet_t rx_octet,
  output logic rx_valid,
  input wire logic scramble_en,
  output logic rx_sync_indication
);
  localparam int SL = poi_pkg::SCR_LEN;
  localparam int TA = poi_pkg::SCR_TAP_A - 1;
  localparam int TB = poi_pkg::SCR_TAP_B - 1;
  localparam int MSB = poi_pkg::OCTET_W - 1;

  // user octets carry the line-first bit at index MSB; the core
  // numbers it 0 so serial processing starts at the LSB
  function automatic poi_pkg::poi_octet_t bit_rev(
    input poi_pkg::poi_octet_t d
  );
    poi_pkg::poi_octet_t r;
    r = poi_pkg::IDLE_OCTET;
    for (int i = 0; i <= MSB; i++) begin
      r[i] = d[MSB-i]; // RULE7
    end
    return r;
  endfunction

  // system domain, transmit hand-off
  logic req_t;
  logic next_req_t;
  poi_pkg::poi_octet_t tx_hold;
  poi_pkg::poi_octet_t next_tx_hold;
  logic ack_s1;
  logic ack_s2;
  // system domain, receive and status
  logic rxt_s1;
  logic rxt_s2;
  logic rxt_s3;
  poi_pkg::poi_octet_t next_rx_octet;
  logic next_rx_valid;
  logic st_s1;
  // link domain
  logic rs1;
  logic rs2;
  logic rst_link;
  logic req_s1;
  logic req_s2;
  logic scr_s1;
  logic scr_s2;
  logic ack_t;
  logic next_ack_t;
  poi_pkg::poi_octet_t lhold;
  poi_pkg::poi_octet_t next_lhold;
  logic lhold_full;
  logic next_lhold_full;
  poi_pkg::poi_octet_t tx_sh;
  poi_pkg::poi_octet_t next_tx_sh;
  logic tx_line_q;
  logic next_tx_line;
  logic [SL-1:0] tx_scr;
  logic [SL-1:0] next_tx_scr;
  logic tx_bit;
  poi_pkg::poi_octet_t rx_sh;
  poi_pkg::poi_octet_t next_rx_sh;
  poi_pkg::poi_bit_idx_t rx_cnt;
  poi_pkg::poi_bit_idx_t next_rx_cnt;
  logic rx_aligned;
  logic next_rx_aligned;
  poi_pkg::poi_octet_t rx_word;
  poi_pkg::poi_octet_t next_rx_word;
  logic rx_tog;
  logic next_rx_tog;
  logic [SL-1:0] rx_scr;
  logic [SL-1:0] next_rx_scr;
  logic rx_bit;

  // ---------------- system domain ----------------
  // a request is in flight until its toggle comes back
  assign tx_ready = (req_t == ack_s2);

  always_comb begin
    next_req_t = req_t;
    next_tx_hold = tx_hold;
    if (tx_valid && tx_ready) begin
      next_req_t = ~req_t;
      next_tx_hold = bit_rev(tx_octet); // RULE7
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      req_t <= 1'b0;
      tx_hold <= poi_pkg::IDLE_OCTET;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      req_t <= next_req_t;
      tx_hold <= next_tx_hold;
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
    end
  end

  always_comb begin
    next_rx_octet = rx_octet;
    next_rx_valid = 1'b0;
    if (rxt_s2 != rxt_s3) begin
      // rx_word is still for a full octet time, far above 3 cycles
      next_rx_octet = bit_rev(rx_word); // RULE6
      next_rx_valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxt_s1 <= 1'b0;
      rxt_s2 <= 1'b0;
      rxt_s3 <= 1'b0;
      rx_octet <= poi_pkg::IDLE_OCTET;
      rx_valid <= 1'b0;
      st_s1 <= 1'b0;
      rx_sync_indication <= 1'b0;
    end else begin
      rxt_s1 <= rx_tog;
      rxt_s2 <= rxt_s1;
      rxt_s3 <= rxt_s2;
      rx_octet <= next_rx_octet;
      rx_valid <= next_rx_valid;
      st_s1 <= link.pmd_steady;
      rx_sync_indication <= st_s1; // RULE11
    end
  end

  // ---------------- link domain ----------------
  // far end holds link_reset while its clock starts up
  assign rst_link = link.link_reset | rs2;
  // without bit timing every link clock carries one bit
  assign tx_bit = HAS_BIT_TIMING ? link.tx_bit_sync : 1'b1; // RULE5
  assign rx_bit = HAS_BIT_TIMING ? link.rx_bit_sync : 1'b1; // RULE5
  assign link.tx_line = tx_line_q; // RULE1

  always_ff @(posedge link.link_clk) begin
    rs1 <= reset;
    rs2 <= rs1;
  end

  // single interleaved stream per direction, no fast bypass
  always_comb begin // RULE8
    poi_pkg::poi_octet_t cur;
    logic sbit;
    cur = tx_sh;
    sbit = 1'b0;
    next_lhold = lhold;
    next_lhold_full = lhold_full;
    next_ack_t = ack_t;
    next_tx_sh = tx_sh;
    next_tx_line = tx_line_q;
    next_tx_scr = tx_scr;
    if (tx_bit) begin
      if (link.tx_octet_sync) begin
        // one octet per timing event, idle fill if none waits
        cur = lhold_full ? lhold : poi_pkg::IDLE_OCTET; // RULE10
        next_lhold_full = 1'b0;
      end
      // core bit 0 leaves first: it is the external MSB
      sbit = cur[0] ^ (scr_s2 & (tx_scr[TA] ^ tx_scr[TB])); // RULE7
      next_tx_line = sbit; // RULE2 RULE6
      next_tx_scr = {tx_scr[SL-2:0], sbit};
      next_tx_sh = cur >> 1;
    end
    // capture only into an empty holder; source data is stable
    if (!lhold_full && (req_s2 != ack_t)) begin
      next_lhold = tx_hold;
      next_lhold_full = 1'b1;
      next_ack_t = req_s2;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_link) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      scr_s1 <= 1'b0;
      scr_s2 <= 1'b0;
      ack_t <= 1'b0;
      lhold <= poi_pkg::IDLE_OCTET;
      lhold_full <= 1'b0;
      tx_sh <= poi_pkg::IDLE_OCTET;
      tx_line_q <= 1'b0;
      tx_scr <= '0;
    end else begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      scr_s1 <= scramble_en;
      scr_s2 <= scr_s1;
      ack_t <= next_ack_t;
      lhold <= next_lhold;
      lhold_full <= next_lhold_full;
      tx_sh <= next_tx_sh;
      tx_line_q <= next_tx_line;
      tx_scr <= next_tx_scr;
    end
  end

  always_comb begin
    logic dbit;
    dbit = link.rx_line ^ (scr_s2 & (rx_scr[TA] ^ rx_scr[TB])); // RULE7
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_aligned = rx_aligned;
    next_rx_word = rx_word;
    next_rx_tog = rx_tog;
    next_rx_scr = rx_scr;
    if (rx_bit) begin
      next_rx_scr = {rx_scr[SL-2:0], link.rx_line};
      // first bit in lands at core bit 0 after eight shifts
      next_rx_sh = {dbit, rx_sh[MSB:1]}; // RULE2
      if (link.rx_octet_sync) begin
        next_rx_cnt = poi_pkg::BIT_FIRST; // RULE10
        next_rx_aligned = 1'b1;
      end else begin
        next_rx_cnt = rx_cnt + 1'b1;
        if (rx_aligned && (rx_cnt + 1'b1 == poi_pkg::BIT_LAST)) begin
          next_rx_word = {dbit, rx_sh[MSB:1]}; // RULE10
          next_rx_tog = ~rx_tog;
        end
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_link) begin
      rx_sh <= poi_pkg::IDLE_OCTET;
      rx_cnt <= poi_pkg::BIT_FIRST;
      rx_aligned <= 1'b0;
      rx_word <= poi_pkg::IDLE_OCTET;
      rx_tog <= 1'b0;
      rx_scr <= '0;
    end else begin
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_aligned <= next_rx_aligned;
      rx_word <= next_rx_word;
      rx_tog <= next_rx_tog;
      rx_scr <= next_rx_scr;
    end
  end
endmodule

// file: poi_pmd.sv
`timescale 1ns/1ns
module poi_pmd #(
  parameter int LINK_DIV = poi_pkg::LINK_DIV,
  parameter bit HAS_BIT_TIMING = 1'b1,
  parameter int RATE_W = poi_pkg::RATE_W
) (
  input wire logic clock,
  input wire logic reset,
  poi_link_if.pmd link,
  input wire logic [RATE_W-1:0] tx_rate_div,
  input wire logic [RATE_W-1:0] rx_rate_div,
  input wire logic steady_state,
  output poi_pkg::poi_octet_t tx_octet,
  output logic tx_valid,
  input wire poi_pkg::poi_octet_t rx_octet,
  input wire logic rx_valid,
  output logic rx_ready
);
  localparam int DW = $clog2(LINK_DIV + 1);
  localparam int RW = $clog2(poi_pkg::LINK_RST_CYCLES + 1);
  localparam int MSB = poi_pkg::OCTET_W - 1;
  localparam logic [DW-1:0] C_LAST = DW'(LINK_DIV - 1);
  localparam logic [DW-1:0] C_HALF = DW'(LINK_DIV / 2);
  localparam logic [RW-1:0] R_LAST = RW'(poi_pkg::LINK_RST_CYCLES - 1);
  localparam logic [RATE_W-1:0] R_ZERO = '0;

  logic [DW-1:0] div_c;
  logic [DW-1:0] next_div_c;
  logic clk_q;
  logic next_clk;
  logic [RW-1:0] rst_cnt;
  logic [RW-1:0] next_rst_cnt;
  logic lrst;
  logic next_lrst;
  logic steady_q;
  logic next_steady;
  logic fall;
  logic rise;
  logic [RATE_W-1:0] tx_rc;
  logic [RATE_W-1:0] next_tx_rc;
  logic tx_stb;
  logic next_tx_stb;
  logic tx_sync;
  logic next_tx_sync;
  poi_pkg::poi_bit_idx_t tx_idx;
  poi_pkg::poi_bit_idx_t next_tx_idx;
  logic tx_prev_sync;
  logic next_tx_prev_sync;
  logic tx_seen;
  logic next_tx_seen;
  poi_pkg::poi_bit_idx_t tx_n;
  poi_pkg::poi_bit_idx_t next_tx_n;
  poi_pkg::poi_octet_t tx_sh;
  poi_pkg::poi_octet_t next_tx_sh;
  poi_pkg::poi_octet_t next_tx_octet;
  logic next_tx_valid;
  logic [RATE_W-1:0] rx_rc;
  logic [RATE_W-1:0] next_rx_rc;
  logic rx_stb;
  logic next_rx_stb;
  logic rx_sync;
  logic next_rx_sync;
  poi_pkg::poi_bit_idx_t rx_idx;
  poi_pkg::poi_bit_idx_t next_rx_idx;
  poi_pkg::poi_octet_t rx_cur;
  poi_pkg::poi_octet_t next_rx_cur;
  logic rx_line_q;
  logic next_rx_line;
  logic next_rx_ready;

  // divisor 0 is taken as 1
  function automatic logic [RATE_W-1:0] reload(input logic [RATE_W-1:0] d);
    return (d == R_ZERO) ? R_ZERO : d - 1'b1;
  endfunction

  // link signals change at the falling link edge, sampled at the rise
  assign fall = (div_c == C_HALF - 1'b1);
  assign rise = (div_c == C_LAST);
  assign link.link_clk = clk_q;
  assign link.link_reset = lrst;
  assign link.pmd_steady = steady_q;
  assign link.tx_bit_sync = tx_stb; // RULE5
  assign link.rx_bit_sync = rx_stb; // RULE5
  assign link.tx_octet_sync = tx_sync; // RULE4
  assign link.rx_octet_sync = rx_sync; // RULE4
  assign link.rx_line = rx_line_q; // RULE1

  always_comb begin
    next_div_c = rise ? '0 : div_c + 1'b1;
    next_clk = (next_div_c < C_HALF);
    next_rst_cnt = rst_cnt;
    next_lrst = lrst;
    next_steady = steady_q;
    if (fall) begin
      next_steady = steady_state;
      if (lrst) begin
        next_rst_cnt = rst_cnt + 1'b1;
        next_lrst = (rst_cnt != R_LAST);
      end
    end
  end

  // link clock starts right after reset so the far end sees edges
  // while link_reset is still held
  always_ff @(posedge clock) begin
    if (reset) begin
      div_c <= '0;
      clk_q <= 1'b1;
      rst_cnt <= '0;
      lrst <= 1'b1;
      steady_q <= 1'b0;
    end else begin
      div_c <= next_div_c;
      clk_q <= next_clk;
      rst_cnt <= next_rst_cnt;
      lrst <= next_lrst;
      steady_q <= next_steady;
    end
  end

  always_comb begin
    next_tx_rc = tx_rc;
    next_tx_stb = tx_stb;
    next_tx_sync = tx_sync;
    next_tx_idx = tx_idx;
    next_tx_prev_sync = tx_prev_sync;
    next_tx_seen = tx_seen;
    next_tx_n = tx_n;
    next_tx_sh = tx_sh;
    next_tx_octet = tx_octet;
    next_tx_valid = 1'b0;
    if (fall) begin
      next_tx_stb = 1'b0;
      next_tx_sync = 1'b0;
      if (!lrst) begin
        // per-direction configured bit rate
        next_tx_stb = !HAS_BIT_TIMING || (tx_rc == R_ZERO); // RULE3
        next_tx_rc = (tx_rc == R_ZERO) ? reload(tx_rate_div) : tx_rc - 1'b1;
        if (next_tx_stb) begin
          next_tx_sync = (tx_idx == poi_pkg::BIT_FIRST); // RULE4
          next_tx_idx = tx_idx + 1'b1;
        end
      end
    end
    // bit on the line was launched at the previous strobe
    if (rise && tx_stb) begin
      next_tx_sh = {tx_sh[MSB-1:0], link.tx_line}; // RULE2
      next_tx_prev_sync = tx_sync;
      if (tx_prev_sync) begin
        next_tx_n = poi_pkg::BIT_FIRST;
        next_tx_seen = 1'b1;
      end else begin
        next_tx_n = tx_n + 1'b1;
      end
      if (tx_seen && !tx_prev_sync && (next_tx_n == poi_pkg::BIT_LAST)) begin
        next_tx_octet = next_tx_sh;
        next_tx_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_rc <= '0;
      tx_stb <= 1'b0;
      tx_sync <= 1'b0;
      tx_idx <= poi_pkg::BIT_FIRST;
      tx_prev_sync <= 1'b0;
      tx_seen <= 1'b0;
      tx_n <= poi_pkg::BIT_FIRST;
      tx_sh <= poi_pkg::IDLE_OCTET;
      tx_octet <= poi_pkg::IDLE_OCTET;
      tx_valid <= 1'b0;
    end else begin
      tx_rc <= next_tx_rc;
      tx_stb <= next_tx_stb;
      tx_sync <= next_tx_sync;
      tx_idx <= next_tx_idx;
      tx_prev_sync <= next_tx_prev_sync;
      tx_seen <= next_tx_seen;
      tx_n <= next_tx_n;
      tx_sh <= next_tx_sh;
      tx_octet <= next_tx_octet;
      tx_valid <= next_tx_valid;
    end
  end

  always_comb begin
    poi_pkg::poi_octet_t cur;
    cur = rx_cur;
    next_rx_rc = rx_rc;
    next_rx_stb = rx_stb;
    next_rx_sync = rx_sync;
    next_rx_idx = rx_idx;
    next_rx_cur = rx_cur;
    next_rx_line = rx_line_q;
    next_rx_ready = 1'b0;
    if (fall) begin
      next_rx_stb = 1'b0;
      next_rx_sync = 1'b0;
      if (!lrst) begin
        next_rx_stb = !HAS_BIT_TIMING || (rx_rc == R_ZERO); // RULE3
        next_rx_rc = (rx_rc == R_ZERO) ? reload(rx_rate_div) : rx_rc - 1'b1;
        if (next_rx_stb) begin
          if (rx_idx == poi_pkg::BIT_FIRST) begin
            cur = rx_valid ? rx_octet : poi_pkg::IDLE_OCTET;
            next_rx_ready = rx_valid;
            next_rx_sync = 1'b1; // RULE4
          end
          next_rx_line = cur[MSB]; // RULE2
          next_rx_cur = cur << 1;
          next_rx_idx = rx_idx + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_rc <= '0;
      rx_stb <= 1'b0;
      rx_sync <= 1'b0;
      rx_idx <= poi_pkg::BIT_FIRST;
      rx_cur <= poi_pkg::IDLE_OCTET;
      rx_line_q <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      rx_rc <= next_rx_rc;
      rx_stb <= next_rx_stb;
      rx_sync <= next_rx_sync;
      rx_idx <= next_rx_idx;
      rx_cur <= next_rx_cur;
      rx_line_q <= next_rx_line;
      rx_ready <= next_rx_ready;
    end
  end
endmodule
